//--- verilog/cmps_defines.vh
// constants for the clock manager phase step and status block
// Overview of operation
// - enabled cycle with direction high adds one fine delay step
// - enabled cycle with direction low removes one fine delay step
// - step logic is timed by the adjust clock
// - step applied within bound, then completion pulses for one cycle
// - completion means ready; user waits for it before next request
// - step count stays within plus or minus step limit
// - actual delay lies between count times min and max step
// - unit reset returns accumulated shift to zero
// - unit reset is asynchronous, clears taps and drops lock
// - reset leaves design-time configuration unchanged
// - lock high when input and feedback are in phase
// - status bit 1 flags stopped input clock, needs feedback
// - status bit 2 flags stopped synthesized clock output
// - status bus eight bits, bits 0 and 3 to 6 reserved zero
// - with hold option, startup stays until lock, default off
// - lock wait selects which of six startup cycles stalls
// - enable and direction inputs may be true or inverted polarity; clock sense inversion has no effect
// - shift mode none, fixed or variable
// - initial shift from -255 to +255
`ifndef CMPS_DEFINES_VH
`define CMPS_DEFINES_VH
`define CMPS_MODE_NONE 2'h0
`define CMPS_MODE_FIXED 2'h1
`define CMPS_MODE_VARIABLE 2'h2
`define CMPS_CLK_PERIOD_NS 8
`define CMPS_STEP_LIMIT (20 * (`CMPS_CLK_PERIOD_NS - 3))
`define CMPS_APPLY_CYCLES 100
`define CMPS_DONE_DELAY 3
`define CMPS_STOP_CYCLES 16
`define CMPS_RST_MIN_CYCLES 3
`define CMPS_STARTUP_CYCLES 6
`define CMPS_STAT_IN_STOP 1
`define CMPS_STAT_FX_STOP 2
`endif

//--- verilog/cmps_sync.v
// two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
module cmps_sync #(
    parameter WIDTH = 1
) (
    input wire clk, // sampling clock
    input wire rstN, // async reset, active low
    input wire [WIDTH-1:0] din, // asynchronous inputs
    output wire [WIDTH-1:0] dout // synchronised outputs
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1_reg;
            reg stage2_reg;
            always @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= din[i];
                    stage2_reg <= stage1_reg;
                end
            end
            assign dout[i] = stage2_reg;
        end
    endgenerate
endmodule

//--- verilog/cmps_phase_status.v
// phase step control, reset, lock and status logic of the clock manager
`timescale 1ns/100ps
`include "cmps_defines.vh"
module cmps_phase_status #(
    parameter [1:0] SHIFT_MODE = `CMPS_MODE_VARIABLE, // shift_mode_select
    parameter integer INIT_SHIFT = 0, // initial_shift_value
    parameter integer STEP_LIMIT = `CMPS_STEP_LIMIT, // step limit
    parameter integer APPLY_CYCLES = `CMPS_APPLY_CYCLES, // apply wait
    parameter integer STOP_CYCLES = `CMPS_STOP_CYCLES, // stop window
    parameter HOLD_CONFIG = 1'b0, // hold_config_until_lock
    parameter [2:0] LOCK_WAIT_SEL = 3'h5, // lock_wait_cycle_select
    parameter INV_ENABLE = 1'b0, // invert phase_adj_enable
    parameter INV_DIRECTION = 1'b0, // invert phase_step_direction
    parameter INV_CLOCK = 1'b0 // phase_adj_clock sense, no effect (applied twice to enable)
) (
    input wire ref_clk, // 125 MHz block and adjust clock
    input wire nrst, // async reset, active low
    input wire unitReset, // unit_reset, async, active high
    input wire phaseAdjEnable, // phase_adj_enable pin
    input wire phaseStepDirection, // phase_step_direction pin
    input wire feedbackClockIn, // feedback_clock_in level
    input wire inputClockPin, // input_clock_pin level
    input wire synthClockOut, // synth_clock_out level
    input wire feedbackUsed, // feedback path connected
    input wire synthUsed, // synthesized output connected
    input wire allLocksIn, // lock of all other holding managers
    output reg phaseAdjComplete, // phase_adj_complete pulse
    output reg lockIndicator, // lock_indicator
    output wire [7:0] status, // status bus
    output reg signed [9:0] stepCount, // accumulated step count
    output reg [2:0] startupCycle, // startup cycle index
    output reg userMode // configuration finished
);
    // ***************************************************
    // reset and input synchronisation
    // ***************************************************
    wire rstIn = nrst & ~unitReset;
    reg rstMeta_reg;
    reg rstSync_reg;
    always @(posedge ref_clk or negedge rstIn) begin
        if (!rstIn) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    wire rstN = rstSync_reg;

    wire [5:0] pinSync;
    cmps_sync #(.WIDTH(6)) u_sync (
        .clk(ref_clk),
        .rstN(rstN),
        .din({phaseAdjEnable, phaseStepDirection, feedbackClockIn,
              inputClockPin, synthClockOut, allLocksIn}),
        .dout(pinSync)
    );
    wire enIn = pinSync[5] ^ INV_ENABLE ^ INV_CLOCK ^ INV_CLOCK;
    wire dirIn = pinSync[4] ^ INV_DIRECTION;
    wire fbIn = pinSync[3];
    wire ckIn = pinSync[2];
    wire fxIn = pinSync[1];
    wire locksIn = pinSync[0];

    // ***************************************************
    // phase step state machine
    // ***************************************************
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_APPLY = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] waitCnt_reg;
    reg [7:0] waitCnt_next;
    reg dir_reg;
    reg dir_next;
    reg signed [9:0] count_next;
    reg done_next;
    wire variableMode = (SHIFT_MODE == `CMPS_MODE_VARIABLE);
    wire signed [9:0] limitPos = STEP_LIMIT[9:0];
    wire signed [9:0] limitNeg = -limitPos;
    wire signed [9:0] initCount =
        (SHIFT_MODE == `CMPS_MODE_NONE) ? 10'sh000 : INIT_SHIFT[9:0];

    always @* begin
        state_next = state_reg;
        waitCnt_next = waitCnt_reg;
        dir_next = dir_reg;
        count_next = stepCount;
        done_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (variableMode && enIn) begin
                    dir_next = dirIn;
                    waitCnt_next = 8'h00;
                    state_next = ST_APPLY;
                end
            end
            ST_APPLY: begin
                if (waitCnt_reg >= APPLY_CYCLES[7:0] - 8'h01) begin
                    if (dir_reg && stepCount < limitPos) begin
                        count_next = stepCount + 10'sh001;
                    end else if (!dir_reg && stepCount > limitNeg) begin
                        count_next = stepCount - 10'sh001;
                    end
                    waitCnt_next = 8'h00;
                    state_next = ST_DONE;
                end else begin
                    waitCnt_next = waitCnt_reg + 8'h01;
                end
            end
            ST_DONE: begin
                if (waitCnt_reg >= `CMPS_DONE_DELAY - 2) begin
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    waitCnt_next = waitCnt_reg + 8'h01;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= ST_IDLE;
            waitCnt_reg <= 8'h00;
            dir_reg <= 1'b0;
            stepCount <= 10'sh000;
            phaseAdjComplete <= 1'b0;
        end else begin
            state_reg <= state_next;
            waitCnt_reg <= waitCnt_next;
            dir_reg <= dir_next;
            stepCount <= (state_reg == ST_IDLE && !variableMode) ?
                         initCount : count_next;
            phaseAdjComplete <= done_next;
        end
    end

    // ***************************************************
    // clock activity and lock
    // ***************************************************
    reg fbPrev_reg;
    reg ckPrev_reg;
    reg fxPrev_reg;
    reg [7:0] fbIdle_reg;
    reg [7:0] ckIdle_reg;
    reg [7:0] fxIdle_reg;
    wire [7:0] stopMax = STOP_CYCLES[7:0];
    wire fbStop = (fbIdle_reg >= stopMax);
    wire ckStop = (ckIdle_reg >= stopMax);
    wire fxStop = (fxIdle_reg >= stopMax);

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            fbPrev_reg <= 1'b0;
            ckPrev_reg <= 1'b0;
            fxPrev_reg <= 1'b0;
            fbIdle_reg <= 8'h00;
            ckIdle_reg <= 8'h00;
            fxIdle_reg <= 8'h00;
            lockIndicator <= 1'b0;
        end else begin
            fbPrev_reg <= fbIn;
            ckPrev_reg <= ckIn;
            fxPrev_reg <= fxIn;
            fbIdle_reg <= (fbIn != fbPrev_reg) ? 8'h00 :
                          (fbStop ? fbIdle_reg : fbIdle_reg + 8'h01);
            ckIdle_reg <= (ckIn != ckPrev_reg) ? 8'h00 :
                          (ckStop ? ckIdle_reg : ckIdle_reg + 8'h01);
            fxIdle_reg <= (fxIn != fxPrev_reg) ? 8'h00 :
                          (fxStop ? fxIdle_reg : fxIdle_reg + 8'h01);
            // in phase: both toggling, same level, no step pending
            lockIndicator <= !fbStop && !ckStop &&
                             (fbIn == ckIn) && (state_reg == ST_IDLE);
        end
    end

    assign status = {5'h00,
                     synthUsed & fxStop,
                     feedbackUsed & ckStop,
                     1'b0};

    // ***************************************************
    // startup sequencing
    // ***************************************************
    wire stall = HOLD_CONFIG && (startupCycle == LOCK_WAIT_SEL) &&
                 !(lockIndicator && locksIn);
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            startupCycle <= 3'h0;
            userMode <= 1'b0;
        end else if (!userMode && !stall) begin
            if (startupCycle == `CMPS_STARTUP_CYCLES - 1) begin
                userMode <= 1'b1;
            end else begin
                startupCycle <= startupCycle + 3'h1;
            end
        end
    end
endmodule

//--- test/cmps_user_model.sv
// user logic model issuing phase step requests
`timescale 1ns/100ps
module cmps_user_model (
    input wire ref_clk, // adjust clock
    input wire go, // issue one request
    input wire dirIn, // wanted direction
    input wire burst, // stretch enable to three cycles
    input wire phaseAdjComplete, // completion pulse
    output reg phaseAdjEnable = 1'b0, // request strobe
    output reg phaseStepDirection = 1'b0, // step direction
    output reg busy = 1'b0 // request outstanding
);
    reg [1:0] hold = 2'h0;
    always @(posedge ref_clk) begin
        if (phaseAdjComplete) begin
            busy <= 1'b0;
        end
        if (go && !busy) begin
            phaseAdjEnable <= 1'b1;
            phaseStepDirection <= dirIn;
            busy <= 1'b1;
            hold <= burst ? 2'h2 : 2'h0;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else begin
            phaseAdjEnable <= 1'b0;
            // direction is meaningless when idle
            phaseStepDirection <= ~phaseStepDirection;
        end
    end
endmodule

//--- test/cmps_phase_status_checker.sv
// assertions on the phase step and status ports
`timescale 1ns/100ps
module cmps_phase_status_checker #(
    parameter integer STEP_LIMIT = 100
) (
    input wire ref_clk, // clock
    input wire nrst, // reset, active low
    input wire unitReset, // unit reset
    input wire feedbackUsed, // feedback connected
    input wire synthUsed, // synth output connected
    input wire phaseAdjComplete, // completion pulse
    input wire lockIndicator, // lock
    input wire [7:0] status, // status bus
    input wire signed [9:0] stepCount, // step count
    input wire userMode // configuration done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst || unitReset);
    done_single_a: assert property (phaseAdjComplete |=> !phaseAdjComplete)
        else $error("completion longer than one cycle");
    step_done_a: assert property ($changed(stepCount) |-> ##2 phaseAdjComplete)
        else $error("no completion after step");
    step_unit_a: assert property ($changed(stepCount) |->
        stepCount - $past(stepCount) == 1 || $past(stepCount) - stepCount == 1)
        else $error("step not one unit");
    step_bound_a: assert property (stepCount <= STEP_LIMIT
        && stepCount >= -STEP_LIMIT)
        else $error("step count out of range");
    reset_clear_a: assert property (disable iff (!nrst) unitReset |->
        stepCount == 0 && !lockIndicator && !phaseAdjComplete)
        else $error("unit reset left state");
    rsvd_zero_a: assert property ({status[6:3], status[0]} == 5'h00)
        else $error("reserved status bit set");
    in_stop_gate_a: assert property (!feedbackUsed [*3] |-> !status[1])
        else $error("input stop without feedback");
    fx_stop_gate_a: assert property (!synthUsed [*3] |-> !status[2])
        else $error("synth stop while unused");
    mode_lock_a: assert property ($rose(userMode) |->
        lockIndicator || $past(lockIndicator))
        else $error("user mode before lock");
    cover property (phaseAdjComplete);
    cover property ($rose(userMode));
    cover property (status[1] ##1 status[2]);
endmodule
bind cmps_phase_status cmps_phase_status_checker #(
    .STEP_LIMIT(STEP_LIMIT)) chk (.ref_clk(ref_clk), .nrst(nrst),
    .unitReset(unitReset), .feedbackUsed(feedbackUsed),
    .synthUsed(synthUsed), .phaseAdjComplete(phaseAdjComplete),
    .lockIndicator(lockIndicator), .status(status),
    .stepCount(stepCount), .userMode(userMode));

//--- test/testbench.sv
// self-checking bench for the phase step and status block
`timescale 1ns/100ps
module testbench;
    reg ref_clk = 0;
    reg nrst = 0;
    reg unitReset = 0, go = 0, dirIn = 0, burst = 0, locks = 0;
    reg inClk = 0, fbClk = 0, fxClk = 0, runIn = 0, runFx = 0;
    reg fbSkew = 0, fbUsed = 1, fxUsed = 1;
    wire en, dir, done, lock, uMode;
    wire [7:0] status;
    wire signed [9:0] steps;
    wire [2:0] stage;
    integer failures = 0, check_count = 0, cyc = 0, i, k, exp;
    always #4 ref_clk = ~ref_clk;
    // slow clock levels, one toggle per four cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 0 && runIn) begin
            inClk <= ~inClk;
            fbClk <= fbSkew ? inClk : ~inClk;
        end
        if (cyc % 4 == 2 && runFx) begin
            fxClk <= ~fxClk;
        end
        if (cyc == 20000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    cmps_user_model user (.ref_clk(ref_clk), .go(go), .dirIn(dirIn),
        .burst(burst), .phaseAdjComplete(done), .phaseAdjEnable(en),
        .phaseStepDirection(dir), .busy());
    cmps_phase_status #(.STEP_LIMIT(2), .APPLY_CYCLES(4),
        .HOLD_CONFIG(1'b1)) uut (.ref_clk(ref_clk), .nrst(nrst),
        .unitReset(unitReset), .phaseAdjEnable(en),
        .phaseStepDirection(dir), .feedbackClockIn(fbClk),
        .inputClockPin(inClk), .synthClockOut(fxClk),
        .feedbackUsed(fbUsed), .synthUsed(fxUsed), .allLocksIn(locks),
        .phaseAdjComplete(done), .lockIndicator(lock), .status(status),
        .stepCount(steps), .startupCycle(stage), .userMode(uMode));
    task check(input [9:0] seen, input [9:0] want);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                failures = failures + 1;
                $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task step(input d, input b);
        begin
            @(posedge ref_clk);
            go <= 1'b1;
            dirIn <= d;
            burst <= b;
            @(posedge ref_clk);
            go <= 1'b0;
            for (i = 0; i < 40 && done !== 1'b1; i = i + 1) begin
                tick(1);
            end
            check(i < 40, 1);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        runIn <= 1'b1;
        runFx <= 1'b1;
        tick(40);
        check(lock, 1);
        check(uMode, 0);
        check(stage, 5);
        @(posedge ref_clk);
        locks <= 1'b1;
        tick(12);
        check(uMode, 1);
        step(1'b1, 1'b1);
        check(steps, 1);
        exp = 1;
        for (k = 0; k < 8; k = k + 1) begin
            step(k < 3, 1'b0);
            if (k < 3)
                exp = exp < 2 ? exp + 1 : exp;
            else
                exp = exp > -2 ? exp - 1 : exp;
            check(steps, exp[9:0]);
        end
        @(posedge ref_clk);
        unitReset <= 1'b1;
        tick(3);
        check(steps, 0);
        check(lock, 0);
        @(posedge ref_clk);
        unitReset <= 1'b0;
        tick(40);
        check(lock, 1);
        @(posedge ref_clk);
        fbSkew <= 1'b1;
        tick(30);
        check(lock, 0);
        @(posedge ref_clk);
        runIn <= 1'b0;
        tick(30);
        check(status, 10'h002);
        @(posedge ref_clk);
        fbUsed <= 1'b0;
        runFx <= 1'b0;
        tick(30);
        check(status, 10'h004);
        @(posedge ref_clk);
        fxUsed <= 1'b0;
        tick(4);
        check(status, 10'h000);
        finish_test;
    end
endmodule
